// ===== hw/lqm_pkg.sv
// constants for the link quality threshold monitor
package lqm_pkg;
	localparam int ADDR_W = 8;
	// register indices; the byte address is the index times four
	localparam logic [7:0] STATUS_IDX = 8'h1D;
	localparam logic [7:0] ACCESS_IDX = 8'h1E;
	localparam logic [7:0] CTRL_IDX = 8'h1F;
	localparam logic [7:0] STATUS_ADDR = 8'h74;
	localparam logic [7:0] ACCESS_ADDR = 8'h78;
	localparam logic [7:0] CTRL_ADDR = 8'h7C;
	localparam int NUM_PARAM = 6;
	localparam int NUM_FLAGS = 10;
	// status bit positions
	localparam int EQ_LO_BIT = 0;
	localparam int EQ_HI_BIT = 1;
	localparam int GC_LO_BIT = 2;
	localparam int GC_HI_BIT = 3;
	localparam int BW_LO_BIT = 4;
	// access register fields
	localparam int SAMPLE_BIT = 13;
	localparam int WSTROBE_BIT = 12;
	localparam int PSEL_HI = 11;
	localparam int PSEL_LO = 9;
	localparam int HILO_BIT = 8;
	localparam int DATA_HI = 7;
	// control register: bit0 interrupt enable, bit1 power down
	localparam int IRQ_EN_BIT = 0;
	localparam int PWRDN_BIT = 1;
	localparam logic [7:0] THR_LO_RST = 8'h00;
	localparam logic [7:0] THR_HI_RST = 8'hFF;
	localparam logic [7:0] DATA_RST = 8'h80;
	localparam logic [2:0] PSEL_RST = 3'h0;
	localparam logic [2:0] PSEL_MAX = 3'h5;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ===== hw/lqm_compare.sv
// one parameter checked against its low and high thresholds
`timescale 1ns/1ps
`default_nettype none
module lqm_compare
(
	input wire logic signed [7:0] value,
	input wire logic signed [7:0] thr_lo,
	input wire logic signed [7:0] thr_hi,
	output logic below,
	output logic above
);
	assign below = value < thr_lo;
	assign above = value > thr_hi;
endmodule
`default_nettype wire

// ===== hw/link_quality_threshold_monitor.sv
// link quality monitor registers, thresholds and warning flags
//
// Function
// - equalizer above high threshold sets flag
// - equalizer below low threshold sets flag
// - gain above high threshold sets flag
// - gain below low threshold sets flag
// - wander below low threshold sets flag
// - warning bits read-only, clear on read
// - no threshold writes while powered down
// - access bits 15:14 read zero
// - sample bit returns live parameter
// - write strobe stores data to selected threshold
// - write strobe self-clears, reads zero
// - three-bit parameter select, six encodings
// - select steers sampling and threshold access
// - low/high bit picks threshold
// - data field: threshold or held sample
// - codes 100/101 address frequency control, variance
// - interrupt only when enabled
// - status read re-arms interrupt
//
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module link_quality_threshold_monitor
	import lqm_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic [7:0] equalizer_coefficient,
	input wire logic [7:0] gain_control_value,
	input wire logic [7:0] baseline_wander_value,
	input wire logic [7:0] freq_offset_value,
	input wire logic [7:0] freq_control_value,
	input wire logic [15:0] variance_upper_value,
	output logic irq
);
	////////////////////////////////////////////////////////////////////
	typedef enum {W_IDLE, W_RESP} wstate_t;
	wstate_t wst_r;
	logic aw_have_r;
	logic w_have_r;
	logic [7:0] aw_addr_r;
	logic [31:0] w_data_r;
	logic [3:0] w_strb_r;
	logic [7:0] thr_r [NUM_PARAM*2];
	logic [NUM_FLAGS-1:0] flags_r;
	logic [2:0] psel_r;
	logic hilo_r;
	logic sample_r;
	logic [7:0] sampled_r;
	logic irq_en_r;
	logic pwrdn_r;
	logic armed_r;
	logic [7:0] live [NUM_PARAM*2];
	logic [NUM_FLAGS-1:0] viol;
	logic wr_fire;
	logic rd_fire;
	logic status_rd;
	logic [31:0] rd_word;
	logic rd_ok;

	// slot index: parameter * 2 + low/high
	function automatic logic [3:0] slot(input logic [2:0] p, input logic h);
		slot = {p, h};
	endfunction

	function automatic logic mapped(input logic [7:0] a);
		mapped = (a == STATUS_ADDR) || (a == ACCESS_ADDR) || (a == CTRL_ADDR);
	endfunction

	////////////////////////////////////////////////////////////////////
	// slot pairs share one live value, except variance: its low and
	// high slots are its two upper bytes; no variance comparator here
	assign live[0] = equalizer_coefficient;
	assign live[2] = gain_control_value;
	assign live[4] = baseline_wander_value;
	assign live[6] = freq_offset_value;
	assign live[8] = freq_control_value;
	assign live[10] = variance_upper_value[7:0];
	assign live[1] = live[0];
	assign live[3] = live[2];
	assign live[5] = live[4];
	assign live[7] = live[6];
	assign live[9] = live[8];
	assign live[11] = variance_upper_value[15:8];

	genvar g;
	generate
		for (g = 0; g < NUM_FLAGS/2; g++)
		begin : cmp
			lqm_compare u_cmp
			(
				.value(live[2*g]),
				.thr_lo(thr_r[2*g]),
				.thr_hi(thr_r[2*g+1]),
				.below(viol[2*g]),
				.above(viol[2*g+1])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////
	// write channel: address and data taken in either order
	assign wr_fire = aw_have_r && w_have_r && (wst_r == W_IDLE);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_have_r <= 1'b0;
			aw_addr_r <= 8'h00;
			awready <= 1'b0;
		end
		else if (wr_fire)
		begin
			aw_have_r <= 1'b0;
			awready <= 1'b0;
		end
		else if (awvalid && awready)
		begin
			aw_have_r <= 1'b1;
			aw_addr_r <= awaddr;
			awready <= 1'b0;
		end
		else
			awready <= !aw_have_r && (wst_r == W_IDLE);
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			w_have_r <= 1'b0;
			w_data_r <= 32'h00000000;
			w_strb_r <= 4'h0;
			wready <= 1'b0;
		end
		else if (wr_fire)
		begin
			w_have_r <= 1'b0;
			wready <= 1'b0;
		end
		else if (wvalid && wready)
		begin
			w_have_r <= 1'b1;
			w_data_r <= wdata;
			w_strb_r <= wstrb;
			wready <= 1'b0;
		end
		else
			wready <= !w_have_r && (wst_r == W_IDLE);
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			wst_r <= W_IDLE;
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
		end
		else
		begin
			case (wst_r)
				W_IDLE:
					if (wr_fire)
					begin
						wst_r <= W_RESP;
						bvalid <= 1'b1;
						bresp <= mapped(aw_addr_r) ? RESP_OKAY : RESP_SLVERR;
					end
				W_RESP:
					if (bready)
					begin
						wst_r <= W_IDLE;
						bvalid <= 1'b0;
					end
				default:
					wst_r <= W_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// access register fields; only the low two byte lanes matter
	logic acc_wr;
	logic ctl_wr;
	assign acc_wr = wr_fire && (aw_addr_r == ACCESS_ADDR);
	assign ctl_wr = wr_fire && (aw_addr_r == CTRL_ADDR) && w_strb_r[0];

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			psel_r <= PSEL_RST;
			hilo_r <= 1'b0;
			sample_r <= 1'b0;
		end
		else if (acc_wr)
		begin
			if (w_strb_r[1])
			begin
				psel_r <= w_data_r[PSEL_HI:PSEL_LO];
				hilo_r <= w_data_r[HILO_BIT];
				sample_r <= w_data_r[SAMPLE_BIT];
			end
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			irq_en_r <= 1'b0;
			pwrdn_r <= 1'b0;
		end
		else if (ctl_wr)
		begin
			irq_en_r <= w_data_r[IRQ_EN_BIT];
			pwrdn_r <= w_data_r[PWRDN_BIT];
		end
	end

	// strobe stores the data byte into the selected slot
	// codes 4 and 5 reach slots 8..11
	// strobe is never stored, so it reads zero
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			for (int i = 0; i < NUM_PARAM; i++)
			begin
				thr_r[2*i] <= THR_LO_RST;
				thr_r[2*i+1] <= THR_HI_RST;
			end
		end
		else if (acc_wr && w_strb_r[1] && w_strb_r[0] &&
			w_data_r[WSTROBE_BIT] && !pwrdn_r &&
			(w_data_r[PSEL_HI:PSEL_LO] <= PSEL_MAX))
			thr_r[slot(w_data_r[PSEL_HI:PSEL_LO], w_data_r[HILO_BIT])]
				<= w_data_r[DATA_HI:0];
	end

	////////////////////////////////////////////////////////////////////
	// read channel, one cycle after address acceptance
	assign rd_fire = arvalid && arready;
	assign status_rd = rd_fire && (araddr == STATUS_ADDR);

	always_comb
	begin
		rd_word = 32'h00000000;
		rd_ok = 1'b1;
		case (araddr)
			STATUS_ADDR:
				rd_word[NUM_FLAGS-1:0] = flags_r;
			ACCESS_ADDR:
			begin
				rd_word[SAMPLE_BIT] = sample_r;
				rd_word[PSEL_HI:PSEL_LO] = psel_r;
				rd_word[HILO_BIT] = hilo_r;
				rd_word[DATA_HI:0] = sample_r ? sampled_r :
					((psel_r <= PSEL_MAX) ? thr_r[slot(psel_r, hilo_r)] : 8'h00);
			end
			CTRL_ADDR:
			begin
				rd_word[IRQ_EN_BIT] = irq_en_r;
				rd_word[PWRDN_BIT] = pwrdn_r;
			end
			default:
				rd_ok = 1'b0;
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			arready <= 1'b0;
			rvalid <= 1'b0;
			rdata <= 32'h00000000;
			rresp <= RESP_OKAY;
		end
		else if (rvalid)
		begin
			arready <= 1'b0;
			if (rready)
				rvalid <= 1'b0;
		end
		else if (rd_fire)
		begin
			arready <= 1'b0;
			rvalid <= 1'b1;
			rdata <= rd_word;
			rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
		end
		else
			arready <= 1'b1;
	end

	// sample taken when the sample bit is written to one
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			sampled_r <= 8'h00;
		else if (acc_wr && w_strb_r[1] && w_data_r[SAMPLE_BIT] &&
			(w_data_r[PSEL_HI:PSEL_LO] <= PSEL_MAX))
			sampled_r <= live[slot(w_data_r[PSEL_HI:PSEL_LO],
				w_data_r[HILO_BIT])];
	end

	////////////////////////////////////////////////////////////////////
	// sticky flags, set beats clear-on-read
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			flags_r <= '0;
		else if (status_rd)
			flags_r <= viol;
		else
			flags_r <= flags_r | viol;
	end

	// one interrupt per arming, re-armed by status read
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			armed_r <= 1'b1;
			irq <= 1'b0;
		end
		else if (status_rd)
		begin
			armed_r <= 1'b1;
			irq <= 1'b0;
		end
		else if (armed_r && irq_en_r && (|flags_r))
		begin
			armed_r <= 1'b0;
			irq <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////
	// set flag stays until read
	a_flag_sticky: assert property (@(posedge aclk)
		disable iff (!aresetn) (|flags_r) && !status_rd |=> (|flags_r))
		else $error("warning flag lost without status read");
	a_eq_high: assert property (@(posedge aclk)
		disable iff (!aresetn) viol[EQ_HI_BIT] |=> flags_r[EQ_HI_BIT])
		else $error("equalizer high flag not set");
	a_eq_low: assert property (@(posedge aclk)
		disable iff (!aresetn) viol[EQ_LO_BIT] |=> flags_r[EQ_LO_BIT])
		else $error("equalizer low flag not set");
	a_gain_high: assert property (@(posedge aclk)
		disable iff (!aresetn)
		($signed(gain_control_value) > $signed(thr_r[3]))
		|=> flags_r[GC_HI_BIT])
		else $error("gain high flag not set");
	a_gain_low: assert property (@(posedge aclk)
		disable iff (!aresetn)
		($signed(gain_control_value) < $signed(thr_r[2]))
		|=> flags_r[GC_LO_BIT])
		else $error("gain low flag not set");
	a_wander_low: assert property (@(posedge aclk)
		disable iff (!aresetn)
		($signed(baseline_wander_value) < $signed(thr_r[4]))
		|=> flags_r[BW_LO_BIT])
		else $error("wander low flag not set");
	a_read_clears: assert property (@(posedge aclk)
		disable iff (!aresetn) status_rd && !(|viol) |=> flags_r == '0)
		else $error("status read did not clear flags");
	a_pwrdn_hold: assert property (@(posedge aclk)
		disable iff (!aresetn)
		pwrdn_r && !ctl_wr |=> thr_r[0] == $past(thr_r[0]))
		else $error("threshold changed while powered down");
	a_irq_gated: assert property (@(posedge aclk)
		disable iff (!aresetn) !irq_en_r && !irq |=> !irq)
		else $error("interrupt raised while disabled");
	a_read_rearm: assert property (@(posedge aclk)
		disable iff (!aresetn) status_rd |=> armed_r && !irq)
		else $error("status read did not re-arm");
	a_top_zero: assert property (@(posedge aclk)
		disable iff (!aresetn)
		rvalid && $past(araddr) == ACCESS_ADDR && $rose(rvalid)
		|-> rdata[15:14] == 2'h0 && rdata[WSTROBE_BIT] == 1'b0)
		else $error("reserved or strobe bit read non-zero");

	c_status_read: cover property (@(posedge aclk) status_rd && (|flags_r));
	c_irq: cover property (@(posedge aclk) $rose(irq));
	c_write: cover property (@(posedge aclk) acc_wr && w_data_r[WSTROBE_BIT]);
	c_sample: cover property (@(posedge aclk) rvalid && sample_r);
endmodule
`default_nettype wire

// ===== tb/tb_top.sv
// self-checking bench for the link quality threshold monitor
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import lqm_pkg::*;
	localparam logic [33:0] ALL = 34'h3_FFFF_FFFF;
	localparam logic [31:0] STROBE = 32'h0000_1000;
	localparam logic [31:0] SAMP = 32'h0000_2000;
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid, irq;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	logic [7:0] live [5];
	logic [15:0] var_val;
	logic [33:0] exp_q [$];
	logic [33:0] msk_q [$];
	int failures = 0;
	int compares = 0;
	int seed = 13229;

	always #25 aclk = ~aclk;

	link_quality_threshold_monitor link_quality_threshold_monitor_inst (
		.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.equalizer_coefficient(live[0]), .gain_control_value(live[1]),
		.baseline_wander_value(live[2]), .freq_offset_value(live[3]),
		.freq_control_value(live[4]), .variance_upper_value(var_val),
		.irq(irq)
	);

	////////////////////////////////////////////////////////////////////////
	task automatic check(input string name, input logic [33:0] seen,
		input logic [33:0] exp);
		compares++;
		if (seen !== exp)
		begin
			failures++;
			$display("unexpected %s: expected %h, seen %h", name, exp, seen);
		end
	endtask

	task automatic stop_test();
		$display("compares %0d, failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	function automatic logic [31:0] acc(input logic [2:0] p, input logic h,
		input logic [7:0] d);
		return (32'(p) << PSEL_LO) | (32'(h) << HILO_BIT) | 32'(d);
	endfunction

	// address and data offered together, each released once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		logic aw_t;
		logic w_t;
		n = 0;
		aw_t = 1'b0;
		w_t = 1'b0;
		@(posedge aclk);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			n++;
			if (awready)
			begin
				awvalid <= 1'b0;
				aw_t = 1'b1;
			end
			if (wready)
			begin
				wvalid <= 1'b0;
				w_t = 1'b1;
			end
		end
		while (!(aw_t && w_t) && n < 40);
		do
		begin
			@(posedge aclk);
			n++;
		end
		while (!bvalid && n < 80);
		bready <= 1'b0;
		check("bresp", {32'h0, bresp}, {32'h0, RESP_OKAY});
		if (n >= 80)
		begin
			failures++;
			stop_test();
		end
	endtask

	// expectation noted first, the monitor below compares it
	task automatic rd(input logic [7:0] a, input logic [33:0] e,
		input logic [33:0] m);
		int n;
		n = 0;
		exp_q.push_back(e);
		msk_q.push_back(m);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			n++;
		end
		while (!arready && n < 40);
		arvalid <= 1'b0;
		do
		begin
			@(posedge aclk);
			n++;
		end
		while (!rvalid && n < 80);
		rready <= 1'b0;
		if (n >= 80)
		begin
			failures++;
			stop_test();
		end
	endtask

	always @(posedge aclk)
	begin
		if (rvalid && rready)
		begin
			if (exp_q.size() == 0)
				failures++;
			else
			begin
				check("rdata", {rresp, rdata} & msk_q[0], exp_q[0]);
				void'(exp_q.pop_front());
				void'(msk_q.pop_front());
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		int p;
		int h;
		logic [7:0] rv;
		{aclk, aresetn, awvalid, wvalid, bready, arvalid, rready} = 7'h00;
		{awaddr, araddr, wdata} = 48'h0;
		wstrb = 4'hF;
		live = '{5{8'h00}};
		var_val = 16'hA55A;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		// select, low/high and sample read as reset
		rd(ACCESS_ADDR, 34'h0, ALL);
		for (p = 0; p < 6; p++)
			for (h = 0; h < 2; h++)
				wr(ACCESS_ADDR, acc(3'(p), 1'(h), h ? 8'h10 : 8'hF0) | STROBE);
		// readback with junk in the top bits
		for (p = 0; p < 6; p++)
			for (h = 0; h < 2; h++)
			begin
				wr(ACCESS_ADDR, 32'h0000_C000 | acc(3'(p), 1'(h), 8'h55));
				rd(ACCESS_ADDR, {2'b0, acc(3'(p), 1'(h), h ? 8'h10 : 8'hF0)},
					ALL);
			end
		// high slots reset to all ones: every high flag was raised
		rd(STATUS_ADDR, 34'h2AA, ALL);
		wr(STATUS_ADDR, 32'h0000_03FF);
		rd(STATUS_ADDR, 34'h0, ALL);
		for (p = 0; p < 5; p++)
			for (h = 0; h < 2; h++)
			begin
				@(posedge aclk);
				live[p] <= h ? 8'h14 : 8'hEC;
				repeat (3) @(posedge aclk);
				live[p] <= 8'h00;
				repeat (3) @(posedge aclk);
				rd(STATUS_ADDR, 34'h1 << (2 * p + h), ALL);
				rd(STATUS_ADDR, 34'h0, ALL);
			end
		// violation during the read keeps its flag
		@(posedge aclk);
		live[2] <= 8'hEC;
		repeat (3) @(posedge aclk);
		rd(STATUS_ADDR, 34'h10, ALL);
		rd(STATUS_ADDR, 34'h10, ALL);
		@(posedge aclk);
		live[2] <= 8'h00;
		repeat (3) @(posedge aclk);
		rd(STATUS_ADDR, 34'h10, ALL);
		rd(STATUS_ADDR, 34'h0, ALL);
		// strobe while powered down is dropped
		wr(CTRL_ADDR, 32'h2);
		wr(ACCESS_ADDR, acc(3'h0, 1'b0, 8'h00) | STROBE);
		rd(ACCESS_ADDR, {2'b0, acc(3'h0, 1'b0, 8'hF0)}, ALL);
		wr(CTRL_ADDR, 32'h0);
		wr(ACCESS_ADDR, acc(3'h0, 1'b0, 8'h00));
		rd(ACCESS_ADDR, {2'b0, acc(3'h0, 1'b0, 8'hF0)}, ALL);
		// live sample, held after the input moves
		rv = 8'($random(seed)) & 8'h0F;
		@(posedge aclk);
		live[1] <= rv;
		wr(ACCESS_ADDR, acc(3'h1, 1'b0, 8'h00) | SAMP);
		rd(ACCESS_ADDR, {2'b0, acc(3'h1, 1'b0, rv) | SAMP}, ALL);
		@(posedge aclk);
		live[1] <= rv ^ 8'h08;
		rd(ACCESS_ADDR, {2'b0, acc(3'h1, 1'b0, rv) | SAMP}, ALL);
		wr(ACCESS_ADDR, acc(3'h5, 1'b1, 8'h00) | SAMP);
		rd(ACCESS_ADDR, {2'b0, acc(3'h5, 1'b1, 8'hA5) | SAMP}, ALL);
		wr(CTRL_ADDR, 32'h1);
		@(posedge aclk);
		live[0] <= 8'h14;
		repeat (3) @(posedge aclk);
		live[0] <= 8'h00;
		repeat (3) @(posedge aclk);
		check("irq", {33'h0, irq}, 34'h1);
		rd(STATUS_ADDR, 34'h2, ALL);
		repeat (2) @(posedge aclk);
		check("irq", {33'h0, irq}, 34'h0);
		wr(CTRL_ADDR, 32'h0);
		@(posedge aclk);
		live[1] <= 8'hEC;
		repeat (3) @(posedge aclk);
		live[1] <= 8'h00;
		repeat (3) @(posedge aclk);
		check("irq", {33'h0, irq}, 34'h0);
		rd(STATUS_ADDR, 34'h4, ALL);
		// unmapped place answers with an error
		rd(8'h40, {RESP_SLVERR, 32'h0}, ALL);
		repeat (4) @(posedge aclk);
		stop_test();
	end
endmodule
`default_nettype wire
